// ===== src/smem_pkg.sv
// Purpose: Shared constants for the 16 x 8-bit bus slave memory
// Assumes: Single bus clock, no reset reaches the storage
// Notes:   Widths and the read style selector live here
package smem_pkg;
    localparam int unsigned SMEM_ADDR_W = 4;
    localparam int unsigned SMEM_DATA_W = 8;
    localparam int unsigned SMEM_NIB_W = 4;
    localparam int unsigned SMEM_DEPTH = 16;
    localparam int unsigned SMEM_NUM_NIB = 2;
    // Read style: 0 asynchronous read primitive, 1 clocked read primitive
    localparam bit SMEM_READ_ASYNC = 1'b0;
    localparam bit SMEM_READ_CLOCKED = 1'b1;
    // Wait-state of a read in the clocked-read variant
    localparam int unsigned SMEM_RD_WAIT = 1;
    // Clock period in ns, for reference only; the logic sets no limit of its own
    localparam int unsigned SMEM_CLK_PERIOD_NS = 8;
endpackage : smem_pkg

// ===== src/smem_portable_sync_ram_model.sv
// Purpose: One nibble-wide portable synchronous-write RAM primitive
// Assumes: Write on rising edge when wr_en_i is high
// Notes:   Read is either combinational or clocked, chosen by parameter
module smem_portable_sync_ram_model #(
    parameter int unsigned WIDTH = smem_pkg::SMEM_NIB_W,
    parameter int unsigned DEPTH = smem_pkg::SMEM_DEPTH,
    parameter int unsigned ADDR_W = smem_pkg::SMEM_ADDR_W,
    parameter bit READ_CLOCKED = smem_pkg::SMEM_READ_ASYNC
) (
    input wire logic clk_i,
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // Refuse a depth that the address cannot cover exactly
    if (DEPTH != (1 << ADDR_W)) begin : g_bad_depth
        $error("Depth must equal two to the address width");
    end

    // Storage has no reset; contents are undefined until written
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_q[addr_i] <= wdata_i;
        end
    end

    // Read style chosen at build time; both pass write data through
    generate
        if (READ_CLOCKED) begin : g_clk_rd
            // Clocked read flop; output belongs to the address of the last edge
            logic [WIDTH-1:0] rd_q;
            always_ff @(posedge clk_i) begin
                rd_q <= wr_en_i ? wdata_i : mem_q[addr_i];
            end
            assign rdata_o = rd_q;
        end else begin : g_async_rd
            // Asynchronous read shows written data at once during a write
            assign rdata_o = wr_en_i ? wdata_i : mem_q[addr_i];
        end
    endgenerate
endmodule // smem_portable_sync_ram_model

// ===== src/smem_top.sv
// Purpose: 16 x 8-bit Wishbone slave memory built from two nibble RAMs
// Assumes: Master supplies clock, strobe, write enable, address, data
// Notes:   READ_CLOCKED selects the one wait-state read variant
// Notes on behaviour
// R1 - Sixteen 8-bit words are held in two 4-bit primitives sharing one address, one nibble each.
// R2 - Write data presented by the master is stored in the addressed word on the rising clock edge.
// R3 - There is no reset input and memory contents are undefined after power-up.
// R4 - With asynchronous-read primitives the acknowledge is the strobe itself, with no wait-state.
// R5 - Read data is valid at the rising edge that follows acknowledge, where the master samples it.
// R6 - In the zero-wait variant read data comes combinationally from the address.
// R7 - With clocked-read primitives every read gets exactly one wait-state, writes get none.
// R8 - The data port is 8 bits with 8-bit granularity, so no byte selects exist.
// R9 - The interface logic adds no clock-frequency limit beyond the primitives.
// R10 - During a write the read data shows the byte being written; with clocked-read primitives it shows it one clock later.
// R11 - The primitive write enable is strobe AND write enable.
module smem_top #(
    parameter bit READ_CLOCKED = smem_pkg::SMEM_READ_ASYNC
) (
    input wire logic clk_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [smem_pkg::SMEM_ADDR_W-1:0] adr_i,
    input wire logic [smem_pkg::SMEM_DATA_W-1:0] dat_i,
    output logic [smem_pkg::SMEM_DATA_W-1:0] dat_o,
    output logic ack_o
);
    logic wr_en;
    logic wait_q;
    logic [1:0] wait_cnt_q;
    logic last_vld_q;
    logic [smem_pkg::SMEM_ADDR_W-1:0] last_adr_q;
    logic [smem_pkg::SMEM_DATA_W-1:0] last_dat_q;

    // A read request is strobe with write enable low; decoded in several places
    function automatic logic smem_is_read(input logic stb, input logic we);
        return stb & ~we;
    endfunction

    // Refuse a data width the two nibble primitives cannot cover
    if (smem_pkg::SMEM_DATA_W != smem_pkg::SMEM_NIB_W * smem_pkg::SMEM_NUM_NIB) begin : g_bad_width
        $error("Data width must be two nibbles");
    end

    // The single wait flop can only add one clock, so refuse any other count
    if (smem_pkg::SMEM_RD_WAIT != 1) begin : g_bad_wait
        $error("Read wait-state count must be one");
    end

    // Address must reach every word of the storage
    if (smem_pkg::SMEM_DEPTH != (1 << smem_pkg::SMEM_ADDR_W)) begin : g_bad_depth
        $error("Depth must equal two to the address width");
    end

    // Single gate in the write path; 8-bit port needs no selects [R11] [R8]
    assign wr_en = stb_i & we_i; // [R11]

    // Two nibble primitives side by side on one address [R1] [R2] [R3]
    genvar gi;
    generate
        for (gi = 0; gi < smem_pkg::SMEM_NUM_NIB; gi++) begin : g_nib
            smem_portable_sync_ram_model #(
                .WIDTH(smem_pkg::SMEM_NIB_W),
                .DEPTH(smem_pkg::SMEM_DEPTH),
                .ADDR_W(smem_pkg::SMEM_ADDR_W),
                .READ_CLOCKED(READ_CLOCKED)
            ) u_ram (
                .clk_i(clk_i),
                .wr_en_i(wr_en),
                .addr_i(adr_i),
                .wdata_i(dat_i[gi*smem_pkg::SMEM_NIB_W +: smem_pkg::SMEM_NIB_W]),
                .rdata_o(dat_o[gi*smem_pkg::SMEM_NIB_W +: smem_pkg::SMEM_NIB_W])
            ); // [R1] [R6] [R10]
        end
    endgenerate

    // Wait-state flop: set on the first cycle of a read, cleared once acked.
    // Fine for back-to-back reads even with the strobe held, as the flop clears itself after one clock.
    // A clocked read runs over two cycles: in the first the primitive samples
    // the address and ack stays low; in the second the flop is set, ack rises
    // and the nibbles hold the addressed word. The master must keep the
    // address steady across both cycles, since the output always belongs to
    // the address of the previous edge. Writes bypass the flop entirely, so
    // they keep zero wait-states. The flop has no reset: it comes up unknown,
    // but one idle clock with the strobe low clears it.
    always_ff @(posedge clk_i) begin
        if (READ_CLOCKED && smem_is_read(stb_i, we_i) && !wait_q) begin
            wait_q <= 1'b1; // [R7]
        end else begin
            wait_q <= 1'b0;
        end
    end

    // Acknowledge is pure gating, so no added clock limit [R9]
    generate
        if (READ_CLOCKED) begin : g_ack_wait
            assign ack_o = stb_i & (we_i | wait_q); // [R7]
        end else begin : g_ack_zero
            assign ack_o = stb_i; // [R4]
        end
    endgenerate

    // Checks. One set of properties serves both variants; most name the
    // variant they apply to and pass vacuously in the other, the rest hold in both. Storage comes
    // up unknown, so read data is only compared once the word was written.
    // Helper logic further down only feeds these checks; the bus never sees it.

    // Acknowledge follows strobe directly in the zero-wait variant
    a_ack_zero_wait: assert property (@(posedge clk_i)
        !READ_CLOCKED |-> (ack_o == stb_i)) // [R4]
        else $error("Ack differs from strobe");

    // Writes are acknowledged at once in both variants
    a_write_ack_now: assert property (@(posedge clk_i)
        (stb_i && we_i) |-> ack_o) // [R7]
        else $error("Write not acked at once");

    // Steps of a clocked read: start, held request, acknowledge; also a clocked write
    sequence s_read_start;
        READ_CLOCKED && smem_is_read(stb_i, we_i) && !wait_q;
    endsequence
    sequence s_read_held;
        smem_is_read(stb_i, we_i) && adr_i == $past(adr_i);
    endsequence
    sequence s_read_ack;
        ack_o && wait_q;
    endsequence
    sequence s_clk_write;
        READ_CLOCKED && wr_en;
    endsequence

    // The first cycle of a clocked read is never acknowledged
    a_read_holds_off: assert property (@(posedge clk_i)
        s_read_start |-> !ack_o) // [R7]
        else $error("Read acked without wait-state");

    // A clocked read still requested after one wait gets its acknowledge
    a_read_one_wait: assert property (@(posedge clk_i)
        s_read_start ##1 smem_is_read(stb_i, we_i) |-> s_read_ack) // [R7]
        else $error("Read wait-state is not one cycle");

    // Back-to-back reads with strobe held each pay their own wait-state
    a_read_rearm: assert property (@(posedge clk_i)
        s_read_start ##1 s_read_ack ##1 smem_is_read(stb_i, we_i) |-> !ack_o) // [R7]
        else $error("Second read acked without wait-state");

    // Write, then a held read of the same word, returns the written byte
    a_clk_store_read: assert property (@(posedge clk_i)
        s_clk_write ##1 s_read_held ##1 s_read_held |-> dat_o == $past(dat_i, 2)) // [R2] [R5]
        else $error("Clocked read did not return stored byte");

    // Two held clocked reads of one word with no write show the same byte
    a_clk_read_hold: assert property (@(posedge clk_i)
        s_read_start ##1 s_read_held ##1 s_read_held |-> $stable(dat_o)) // [R11] [R5]
        else $error("Clocked read changed without write");

    // The clocked primitive passes a written byte on to its output
    a_clk_write_pass: assert property (@(posedge clk_i)
        s_clk_write |=> dat_o == $past(dat_i)) // [R10]
        else $error("Clocked write data not passed to output");

    // Written data is stored and read back at the same address
    a_write_store: assert property (@(posedge clk_i)
        (!READ_CLOCKED && wr_en) ##1 (stb_i && !we_i && adr_i == $past(adr_i))
        |-> dat_o == $past(dat_i)) // [R2]
        else $error("Stored byte not read back");

    // In the zero-wait variant the output shows the incoming byte during a write
    a_write_through: assert property (@(posedge clk_i)
        (!READ_CLOCKED && wr_en) |-> dat_o == dat_i) // [R10]
        else $error("Write data not passed to output");

    // Without write enable memory keeps its value
    a_no_write_hold: assert property (@(posedge clk_i)
        (!READ_CLOCKED && !wr_en && stb_i && !we_i) ##1
        (stb_i && !we_i && adr_i == $past(adr_i)) |-> $stable(dat_o)) // [R11]
        else $error("Memory changed without write");

    // Consecutive unanswered read cycles; saturates so it never wraps
    // back to zero and hides a hang. Helper logic for the checks only.
    always_ff @(posedge clk_i) begin
        if (smem_is_read(stb_i, we_i) && !ack_o) begin
            if (wait_cnt_q != 2'h3) begin
                wait_cnt_q <= wait_cnt_q + 2'h1;
            end
        end else begin
            wait_cnt_q <= 2'h0;
        end
    end

    // Shadow of the most recent write, for the read-back checks only
    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            last_vld_q <= 1'b1;
            last_adr_q <= adr_i;
            last_dat_q <= dat_i;
        end
    end

    // Acknowledge never appears without a strobe in either variant
    a_ack_needs_stb: assert property (@(posedge clk_i)
        ack_o |-> stb_i) // [R4] [R7]
        else $error("Ack without strobe");

    // The wait flop is a one-clock pulse, it can never stretch a read
    a_wait_self_clear: assert property (@(posedge clk_i)
        wait_q |=> !wait_q) // [R7]
        else $error("Wait flop held for two cycles");

    // Only a read can arm the wait flop; writes and idle leave it clear
    a_wait_only_read: assert property (@(posedge clk_i)
        !smem_is_read(stb_i, we_i) |=> !wait_q) // [R7]
        else $error("Wait flop set without a read");

    // No read waits longer than the single wait-state
    a_wait_bounded: assert property (@(posedge clk_i)
        (smem_is_read(stb_i, we_i) && !ack_o) |-> (wait_cnt_q < 2'(smem_pkg::SMEM_RD_WAIT))) // [R7]
        else $error("Read waited too long");

    // The zero-wait variant never holds off a read
    a_async_no_wait: assert property (@(posedge clk_i)
        (!READ_CLOCKED && smem_is_read(stb_i, we_i)) |-> (ack_o && !wait_q)) // [R4] [R6]
        else $error("Zero-wait read was held off");

    // A zero-wait read of the last written word returns that byte at once
    a_last_read_async: assert property (@(posedge clk_i)
        (!READ_CLOCKED && last_vld_q && smem_is_read(stb_i, we_i) && adr_i == last_adr_q)
        |-> dat_o == last_dat_q) // [R2] [R6]
        else $error("Zero-wait read missed last write");

    // A clocked read of the last written word returns it in the ack cycle
    a_last_read_clk: assert property (@(posedge clk_i)
        (READ_CLOCKED && last_vld_q && ack_o && wait_q && $stable(adr_i) && adr_i == last_adr_q)
        |-> dat_o == last_dat_q) // [R2] [R5]
        else $error("Clocked read missed last write");
endmodule // smem_top

// ===== test/smem_master_model.sv
// Purpose: Bus master model facing the slave memory
// Assumes: Requests change just after a rising edge
// Notes: Strobe stays up between back-to-back cycles
module smem_master_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [7:0] rdat_i,
    output logic stb_o,
    output logic we_o,
    output logic [3:0] adr_o,
    output logic [7:0] wdat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idle from time zero, no reset exists
    initial begin
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 4'h0;
        wdat_o = 8'h00;
    end
    // One cycle, bounded to four wait edges
    task automatic cyc(input logic w, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] rd, output int n);
        n = 0;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        wdat_o <= d; // Byte offered for the write
        @(posedge clk_i);
        while (ack_i !== 1'b1 && n < 4) begin // Held until ack
            n++;
            @(posedge clk_i);
        end
        rd = rdat_i; // Taken at the ack edge
    endtask
    // Write enable left high with no strobe
    task automatic idle;
        stb_o <= 1'b0;
        we_o <= 1'b1;
        wdat_o <= 8'hff;
        @(posedge clk_i);
    endtask
endmodule // smem_master_model

// ===== test/smem_top_tb.sv
// Purpose: Self-checking bench, both read styles
// Assumes: Channel 0 async read, channel 1 clocked read
// Notes: Expected bytes come from pat(), except the 3c rewrite of word 9
module smem_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    int n_fail = 0;
    int n_tests = 0;
    wire [1:0] stb, we, ack;
    wire [3:0] adr [2];
    wire [7:0] wd [2], rd [2];
    initial forever #4 clk_i = ~clk_i;
    // One master model per memory variant
    for (genvar g = 0; g < 2; g++) begin : ch
        smem_master_model M (.clk_i(clk_i), .ack_i(ack[g]), .rdat_i(rd[g]), .stb_o(stb[g]), .we_o(we[g]),
            .adr_o(adr[g]), .wdat_o(wd[g]));
        smem_top #(.READ_CLOCKED(g == 1)) DUT (.clk_i(clk_i), .stb_i(stb[g]), .we_i(we[g]), .adr_i(adr[g]),
            .dat_i(wd[g]), .dat_o(rd[g]), .ack_o(ack[g]));
    end
    function automatic logic [7:0] pat(input logic [3:0] a);
        return {a ^ 4'h5, ~a};
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Cycle on channel c, wait count checked, byte too when cd is set
    task automatic xfer(input int c, input logic w, input logic [3:0] a, input logic [7:0] ew, input bit cd);
        logic [7:0] r;
        int n;
        if (c == 1) ch[1].M.cyc(w, a, pat(a), r, n);
        else ch[0].M.cyc(w, a, pat(a), r, n);
        chk("wait states", n[7:0], ew);
        if (cd) chk("data", r, pat(a));
        if (n >= 4) begin // Timeout counted; the run still ends at the verdict
            n_fail++;
        end
    endtask
    // Fill all words, stray write, read back in reverse
    task automatic t_async;
        logic [7:0] r;
        int n;
        for (int a = 0; a < 16; a++) xfer(0, 1'b1, a[3:0], 8'h00, 1'b1);
        ch[0].M.idle(); // Word 15 must survive
        for (int a = 15; a >= 0; a--) xfer(0, 1'b0, a[3:0], 8'h00, 1'b1);
        ch[0].M.cyc(1'b1, 4'h9, 8'h3c, r, n); // Fresh byte over word 9
        ch[0].M.cyc(1'b0, 4'h9, 8'h00, r, n); // Read straight after the write
        chk("rewrite", r, 8'h3c);
        ch[0].M.cyc(1'b0, 4'h9, 8'h00, r, n); // Same word again, no write
        chk("reread", r, 8'h3c);
        chk("reread wait", n[7:0], 8'h00);
        ch[0].M.idle();
    endtask
    // Writes at once, back-to-back reads wait one clock
    task automatic t_clocked;
        xfer(1, 1'b1, 4'h3, 8'h00, 1'b0);
        xfer(1, 1'b1, 4'hc, 8'h00, 1'b0);
        xfer(1, 1'b0, 4'h3, 8'h01, 1'b1);
        xfer(1, 1'b0, 4'hc, 8'h01, 1'b1);
        ch[1].M.idle(); // Stray write enable on word c
        xfer(1, 1'b0, 4'hc, 8'h01, 1'b1); // Word c survives
        xfer(1, 1'b1, 4'h5, 8'h00, 1'b0);
        xfer(1, 1'b0, 4'h5, 8'h01, 1'b1); // Read right after write
        xfer(1, 1'b0, 4'h5, 8'h01, 1'b1); // Same word, own wait-state
        ch[1].M.idle();
    endtask
    // No reset port: bus idle for 6 clocks instead
    initial begin
        repeat (6) @(posedge clk_i);
        t_async();
        t_clocked();
        give_verdict();
    end
endmodule // smem_top_tb
